// ==== icw_pkg.sv ====
// Operation
// RL1: address, four command bytes, data, one frame
// RL2: invalid command leaves register untouched
// RL3: first data byte lands in bits 31:24
// RL4: master sends exactly four data bytes when all are acknowledged; host stops early after a nack
// RL5: master ends with stop or repeated start
// RL6: extra data bytes answered with nack
// RL7: command byte 0 bits 2:0, 011b writes
// RL8: port from cmd1[3:0] and cmd2[7]
// RL9: valid ports 00h, 02h, 03h, 0Ah-0Fh
// RL10: cmd2 bits 5:2 are byte enables
// RL11: disabled bytes keep value, enabled bytes update
// RL12: address from cmd2[1:0] and cmd3, [1:0]=0
// RL13: address byte bits 7:1 address, bit0 write
// RL14: straps low give slave address 38h
// RL15: start, bytes each acknowledged, then stop
// RL16: address bits 2:0 straps, 5:3 one, 6 zero
// RL17: commit only after fourth data byte acknowledged
// RL18: acknowledge own address only, ignore others
package icw_pkg;

	localparam int         CLK_PERIOD_NS = 50;
	localparam int         SCL_PERIOD_NS = 10000;
	localparam int         SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	localparam logic [3:0] SLV_ADDR_HI   = 4'h7;
	localparam logic       DIR_WRITE     = 1'b0;
	localparam logic [2:0] OP_WRITE      = 3'h3;
	localparam logic [3:0] BIT_ACK       = 4'h8;
	localparam logic [3:0] IDX_ADDR      = 4'h0;
	localparam logic [3:0] IDX_CMD_LAST  = 4'h4;
	localparam logic [3:0] IDX_DATA_LAST = 4'h8;
	localparam logic [3:0] IDX_OVER      = 4'h9;
	localparam int         FRAME_BYTES   = 9;

	function automatic logic icw_port_ok(input logic [4:0] p);
		return (p == 5'h00) || (p == 5'h02) || (p == 5'h03) ||
			((p >= 5'h0a) && (p <= 5'h0f));
	endfunction

endpackage

// ==== icw_if.sv ====
`timescale 1ns/10ps
interface icw_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// open-drain wires with pull-up
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);

	modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
		input scl, input sda);
	modport dev (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// ==== icw_sync.sv ====
`timescale 1ns/10ps
module icw_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys, // system clock
	input  wire logic         rst,     // sync reset
	input  wire logic [W-1:0] d,       // asynchronous inputs
	output logic      [W-1:0] q        // synchronised outputs
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // icw_sync

// ==== icw_dev.sv ====
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module icw_dev
	import icw_pkg::*;
(
	input  wire logic        clk_sys, // system clock
	input  wire logic        rst,     // sync reset, active high
	icw_if.dev               bus,     // two-wire link
	input  wire logic [2:0]  strap,   // slave address straps
	output logic             wr_stb,  // one-cycle register write
	output logic [4:0]       wr_port, // target port
	output logic [11:0]      wr_addr, // register byte address
	output logic [3:0]       wr_be,   // byte enables
	output logic [31:0]      wr_data, // write data
	output logic             cmd_bad, // one-cycle: complete command refused
	output logic             busy     // frame in progress, dropped on address mismatch
);
	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SKIP} icw_dst_t;

	icw_dst_t    st_q;
	logic [4:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic [2:0]  strap_s;
	logic        scl_q;
	logic        sda_q;
	logic        start_ev;
	logic        stop_ev;
	logic        scl_rise;
	logic        scl_fall;
	logic [3:0]  bit_q;
	logic [3:0]  byte_q;
	logic [7:0]  shift_q;
	logic [7:0]  cmd_q [0:3];
	logic [31:0] data_q;
	logic        ack_q;
	logic        ack_d;
	logic        addr_match;
	logic [6:0]  own_addr;
	logic        byte_done;
	logic        ack_end;
	logic [4:0]  port_sel;
	logic        cmd_ok;

	icw_sync #(
		.W(5)
	) u_sync (
		.clk_sys(clk_sys),
		.rst    (rst),
		.d      ({strap, bus.sda, bus.scl}),
		.q      (pins_s)
	);

	assign scl_s   = pins_s[0];
	assign sda_s   = pins_s[1];
	assign strap_s = pins_s[4:2];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// frame delimiters and clock edges
	assign start_ev = scl_s && scl_q && sda_q && !sda_s; // RL15
	assign stop_ev  = scl_s && scl_q && !sda_q && sda_s; // RL15
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;

	assign own_addr   = {SLV_ADDR_HI, strap_s}; // RL16 RL14
	assign addr_match = (shift_q[7:1] == own_addr) && (shift_q[0] == DIR_WRITE); // RL13
	assign byte_done  = (st_q == ST_RECV) && scl_fall && (bit_q == BIT_ACK);
	assign ack_end    = (st_q == ST_ACK) && scl_fall;

	always_comb begin
		if (byte_q == IDX_ADDR) begin
			ack_d = addr_match; // RL18
		end else begin
			ack_d = (byte_q <= IDX_DATA_LAST); // RL6
		end
	end

	// frame state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= ST_IDLE;
		end else if (start_ev) begin
			st_q <= ST_RECV; // RL1
		end else if (stop_ev) begin
			st_q <= ST_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					st_q <= ST_IDLE;
				end
				ST_RECV: begin
					if (byte_done) begin
						st_q <= (byte_q == IDX_ADDR && !addr_match) ? ST_SKIP : ST_ACK; // RL18
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						st_q <= ST_RECV;
					end
				end
				ST_SKIP: begin
					st_q <= ST_SKIP;
				end
			endcase
		end
	end

	// bit counter and shifter
	always_ff @(posedge clk_sys) begin
		if (rst || start_ev || ack_end) begin
			bit_q <= 4'h0;
		end else if (st_q == ST_RECV && scl_rise && bit_q != BIT_ACK) begin
			bit_q <= bit_q + 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shift_q <= 8'h00;
		end else if (st_q == ST_RECV && scl_rise && bit_q != BIT_ACK) begin
			shift_q <= {shift_q[6:0], sda_s};
		end
	end

	// byte index, saturates past the last data byte
	always_ff @(posedge clk_sys) begin
		if (rst || start_ev) begin
			byte_q <= IDX_ADDR;
		end else if (ack_end && byte_q != IDX_OVER) begin
			byte_q <= byte_q + 4'h1;
		end
	end

	// command bytes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				cmd_q[i] <= 8'h00;
			end
		end else if (byte_done && byte_q != IDX_ADDR && byte_q <= IDX_CMD_LAST) begin
			cmd_q[2'(byte_q - 4'h1)] <= shift_q; // RL1
		end
	end

	// data bytes, first received ends in bits 31:24
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_q <= 32'h0000_0000;
		end else if (byte_done && byte_q > IDX_CMD_LAST && byte_q <= IDX_DATA_LAST) begin
			data_q <= {data_q[23:0], shift_q}; // RL3
		end
	end

	// acknowledge drive, held through the ninth clock
	always_ff @(posedge clk_sys) begin
		if (rst || start_ev || stop_ev || ack_end) begin
			ack_q <= 1'b0;
		end else if (byte_done) begin
			ack_q <= ack_d; // RL15 RL6
		end
	end

	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = ack_q;

	// decoded command fields
	assign port_sel = {cmd_q[1][3:0], cmd_q[2][7]}; // RL8
	assign cmd_ok   = (cmd_q[0][2:0] == OP_WRITE) && icw_port_ok(port_sel); // RL7 RL9

	// commit after the fourth data byte's acknowledge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_stb  <= 1'b0;
			cmd_bad <= 1'b0;
		end else begin
			wr_stb  <= ack_end && ack_q && byte_q == IDX_DATA_LAST && cmd_ok; // RL17 RL2
			cmd_bad <= ack_end && ack_q && byte_q == IDX_DATA_LAST && !cmd_ok; // RL2
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_port <= 5'h00;
			wr_addr <= 12'h000;
			wr_be   <= 4'h0;
			wr_data <= 32'h0000_0000;
		end else if (ack_end && ack_q && byte_q == IDX_DATA_LAST && cmd_ok) begin
			wr_port <= port_sel; // RL8
			wr_addr <= {cmd_q[2][1:0], cmd_q[3], 2'b00}; // RL12
			wr_be   <= cmd_q[2][5:2]; // RL10 RL11
			wr_data <= data_q; // RL3
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy <= 1'b0;
		end else begin
			busy <= (st_q == ST_RECV) || (st_q == ST_ACK);
		end
	end

endmodule // icw_dev

// ==== icw_host.sv ====
`timescale 1ns/10ps
module icw_host
	import icw_pkg::*;
#(
	parameter int QTR = SCL_QTR_CYC
) (
	input  wire logic        clk_sys,  // system clock
	input  wire logic        rst,      // sync reset, active high
	icw_if.host              bus,      // two-wire link
	input  wire logic        go,       // one-cycle request, taken when idle
	input  wire logic [6:0]  tgt_addr, // slave address
	input  wire logic [4:0]  port,     // target port
	input  wire logic [11:0] reg_addr, // register byte address
	input  wire logic [3:0]  be,       // byte enables
	input  wire logic [31:0] data,     // write data
	output logic             busy,     // transfer in progress
	output logic             done,     // one-cycle end of transfer
	output logic             nack      // last transfer saw a nack
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} icw_hst_t;

	icw_hst_t   st_q;
	logic [7:0] frame_q [0:FRAME_BYTES-1];
	logic [15:0] qcnt_q;
	logic       tick;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [3:0] byte_q;
	logic       bad_q;
	logic       sda_s;
	logic       scl_hi;
	logic       sda_hi;
	logic       scl_oe_q;
	logic       sda_oe_q;
	logic       ph_end;

	icw_sync #(
		.W(1)
	) u_sync (
		.clk_sys(clk_sys),
		.rst    (rst),
		.d      (bus.sda),
		.q      (sda_s)
	);

	assign tick   = (qcnt_q == 16'(QTR - 1));
	assign ph_end = tick && (ph_q == 2'h3);

	always_ff @(posedge clk_sys) begin
		if (rst || st_q == H_IDLE || tick) begin
			qcnt_q <= 16'h0000;
		end else begin
			qcnt_q <= qcnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || st_q == H_IDLE) begin
			ph_q <= 2'h0;
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
		end
	end

	// frame image, loaded at request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < FRAME_BYTES; i++) begin
				frame_q[i] <= 8'h00;
			end
		end else if (go && st_q == H_IDLE) begin
			frame_q[0] <= {tgt_addr, DIR_WRITE}; // RL13
			frame_q[1] <= {5'h00, OP_WRITE}; // RL7
			frame_q[2] <= {4'h0, port[4:1]};
			frame_q[3] <= {port[0], 1'b0, be, reg_addr[11:10]};
			frame_q[4] <= reg_addr[9:2];
			frame_q[5] <= data[31:24];
			frame_q[6] <= data[23:16];
			frame_q[7] <= data[15:8];
			frame_q[8] <= data[7:0]; // RL4
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q   <= H_IDLE;
			bit_q  <= 4'h0;
			byte_q <= 4'h0;
		end else begin
			unique case (st_q)
				H_IDLE: begin
					if (go) begin
						st_q <= H_START; // RL15
					end
				end
				H_START: begin
					if (ph_end) begin
						st_q   <= H_BIT;
						bit_q  <= 4'h0;
						byte_q <= 4'h0;
					end
				end
				H_BIT: begin
					if (ph_end) begin
						if (bit_q != BIT_ACK) begin
							bit_q <= bit_q + 4'h1;
						end else if (bad_q || byte_q == IDX_DATA_LAST) begin
							st_q <= H_STOP; // RL5 RL1
						end else begin
							bit_q  <= 4'h0;
							byte_q <= byte_q + 4'h1;
						end
					end
				end
				H_STOP: begin
					if (ph_end) begin
						st_q <= H_IDLE;
					end
				end
			endcase
		end
	end

	// acknowledge sampled mid-high of the ninth clock
	always_ff @(posedge clk_sys) begin
		if (rst || (go && st_q == H_IDLE)) begin
			bad_q <= 1'b0;
		end else if (st_q == H_BIT && bit_q == BIT_ACK && tick && ph_q == 2'h1) begin
			bad_q <= sda_s; // RL15
		end
	end

	always_comb begin
		scl_hi = 1'b1;
		sda_hi = 1'b1;
		unique case (st_q)
			H_IDLE: begin
				scl_hi = 1'b1;
				sda_hi = 1'b1;
			end
			H_START: begin
				scl_hi = (ph_q != 2'h3);
				sda_hi = (ph_q < 2'h2);
			end
			H_BIT: begin
				scl_hi = (ph_q == 2'h1) || (ph_q == 2'h2);
				sda_hi = (bit_q == BIT_ACK) ? 1'b1 : frame_q[byte_q][3'(4'h7 - bit_q)];
			end
			H_STOP: begin
				scl_hi = (ph_q != 2'h0);
				sda_hi = (ph_q >= 2'h2);
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			scl_oe_q <= !scl_hi;
			sda_oe_q <= !sda_hi;
		end
	end

	assign bus.m_scl_o  = 1'b0;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_scl_oe = scl_oe_q;
	assign bus.m_sda_oe = sda_oe_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
		end else begin
			busy <= (st_q != H_IDLE) || go;
			done <= (st_q == H_STOP) && ph_end;
			if ((st_q == H_STOP) && ph_end) begin
				nack <= bad_q;
			end
		end
	end

endmodule // icw_host

// ==== icw_props.sv ====
`timescale 1ns/10ps
module icw_props #(
	parameter int QTR = 6
) (
	input wire logic clk_sys,  // system clock
	input wire logic rst,      // sync reset
	input wire logic scl,      // clock line
	input wire logic sda,      // data line
	input wire logic s_sda_oe  // device pulls data
);
	localparam int AK_LO = 4 * QTR - 3;
	localparam int AK_HI = 4 * QTR + 3;
	localparam int ST_LO = QTR - 2;
	localparam int ST_HI = QTR + 2;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence start_s;
		scl && $fell(sda);
	endsequence
	sequence stop_s;
		scl && $rose(sda);
	endsequence
	AST_DEV_LOW_PHASE: assert property ($changed(s_sda_oe) |-> !scl)
		else $error("device data moved in high phase");
	AST_ACK_HELD: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe [*8])
		else $error("ack dropped in high phase");
	AST_ACK_LEN: assert property ($rose(s_sda_oe) |-> ##[AK_LO:AK_HI] $fell(s_sda_oe))
		else $error("ack length wrong");
	AST_ACK_TIMING: assert property ($rose(s_sda_oe) |-> !$past(scl, 2) && $past(scl, 6))
		else $error("ack not timed from clock fall");
	AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase short");
	AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
		else $error("clock low phase short");
	AST_DATA_STABLE: assert property ($rose(scl) |-> $stable(sda) [*5])
		else $error("data moved in high phase");
	AST_START_FORM: assert property (start_s |-> !sda throughout (##[ST_LO:ST_HI] $fell(scl)))
		else $error("start not followed by clock fall");
	AST_STOP_IDLE: assert property (stop_s |-> (scl && sda) [*8])
		else $error("bus not idle after stop");
endmodule // icw_props

// ==== icw_tb.sv ====
`timescale 1ns/10ps
module icw_tb;
	localparam int Q = 6;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  strap = 3'h0;
	logic [2:0]  s;
	logic        go = 1'b0;
	logic [6:0]  tgt = 7'h00;
	logic [4:0]  port = 5'h00;
	logic [11:0] radr = 12'h000;
	logic [3:0]  be = 4'h0;
	logic [31:0] data = 32'h0000_0000;
	logic        h_done, h_nack, d_stb, d_bad, s2, h_busy, d_busy;
	logic [4:0]  d_port, p2;
	logic [11:0] d_adr, a2;
	logic [3:0]  d_be, e2;
	logic [31:0] d_dat, w2;
	logic [54:0] exp_q[$];
	logic [54:0] mon_e;
	int          bad_count = 0;
	int          n_compared = 0;
	int          n2 = 0;
	icw_if link();
	icw_if link2();
	assign link2.m_scl_o = 1'b0;
	assign link2.m_sda_o = 1'b0;
	icw_host #(.QTR(Q)) i_icw_host (.clk_sys, .rst, .bus(link), .go, .tgt_addr(tgt), .port,
		.reg_addr(radr), .be, .data, .busy(h_busy), .done(h_done), .nack(h_nack));
	icw_dev i_icw_dev (.clk_sys, .rst, .bus(link), .strap, .wr_stb(d_stb), .wr_port(d_port),
		.wr_addr(d_adr), .wr_be(d_be), .wr_data(d_dat), .cmd_bad(d_bad), .busy(d_busy));
	icw_dev i_icw_dev_2 (.clk_sys, .rst, .bus(link2), .strap(3'h0), .wr_stb(s2), .wr_port(p2),
		.wr_addr(a2), .wr_be(e2), .wr_data(w2), .cmd_bad(), .busy());
	icw_props #(.QTR(Q)) i_icw_props (.clk_sys, .rst, .scl(link.scl), .sda(link.sda),
		.s_sda_oe(link.s_sda_oe));
	always #25 clk_sys = ~clk_sys;
	task automatic chk(input string nm, input logic [54:0] e, input logic [54:0] v);
		n_compared++;
		if (v !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (!rst && (d_stb === 1'b1 || d_bad === 1'b1)) begin
			if (exp_q.size() == 0) chk("unexpected commit", '0, '1);
			else begin
				mon_e = exp_q.pop_front();
				chk("commit", mon_e, mon_e[54] ? {d_bad, d_stb, 53'h0} :
					{d_bad, d_stb, d_port, d_adr, d_be, d_dat});
			end
		end
	end
	always @(posedge clk_sys) if (s2 === 1'b1) n2++;
	task automatic xfer(input logic [6:0] t, input logic [4:0] p, input logic [11:0] a,
			input logic [3:0] b, input logic [31:0] d, input logic hit);
		logic ok;
		ok = (p == 5'h00) || (p == 5'h02) || (p == 5'h03) || (p >= 5'h0a && p <= 5'h0f);
		if (hit) exp_q.push_back(ok ? {2'b01, p, a[11:2], 2'b00, b, d} : {2'b10, 53'h0});
		@(posedge clk_sys);
		go <= 1'b1;
		tgt <= t;
		port <= p;
		radr <= a;
		be <= b;
		data <= d;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		chk("host busy", 55'h1, {54'h0, h_busy});
		if (hit) begin
			// mid command phase: addressed device is busy
			repeat (500) @(posedge clk_sys);
			chk("dev busy", 55'h1, {54'h0, d_busy});
		end
		for (int i = 0; i < 4000 && h_done !== 1'b1; i++) @(posedge clk_sys);
		chk("done nack", {53'h0, 1'b1, !hit}, {53'h0, h_done, h_nack});
		chk("dev idle", 55'h0, {54'h0, d_busy});
	endtask
	task automatic bq;
		repeat (Q) @(posedge clk_sys);
	endtask
	task automatic bit2(input logic v, output logic r);
		link2.m_sda_oe <= !v;
		bq();
		link2.m_scl_oe <= 1'b0;
		bq();
		bq();
		r = link2.sda;
		link2.m_scl_oe <= 1'b1;
		bq();
	endtask
	// raw frame on the second link, acks expected on the first nak bytes
	task automatic frame2(input logic [7:0] a0, input int n, input int nak);
		logic [7:0] pk[10];
		logic r;
		pk = '{a0, 8'h03, 8'h00, 8'h3c, 8'h3e, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
		bq();
		bq();
		link2.m_sda_oe <= 1'b1;
		bq();
		link2.m_scl_oe <= 1'b1;
		bq();
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) bit2(pk[k][i], r);
			bit2(1'b1, r);
			chk("ack", {54'h0, k < nak}, {54'h0, !r});
		end
		link2.m_sda_oe <= 1'b1;
		bq();
		link2.m_scl_oe <= 1'b0;
		bq();
		link2.m_sda_oe <= 1'b0;
		bq();
	endtask
	initial begin
		link2.m_scl_oe = 1'b0;
		link2.m_sda_oe = 1'b0;
		void'($urandom(32'h34c297bc));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		xfer(7'h38, 5'h00, 12'h0f8, 4'hf, 32'h1234_5678, 1'b1);
		for (int p = 0; p < 32; p++)
			xfer(7'h38, p[4:0], 12'($urandom), 4'($urandom), $urandom, 1'b1);
		repeat (3) begin
			s = 3'($urandom);
			strap <= s;
			xfer({4'h7, s}, 5'h0a, 12'($urandom), 4'($urandom), $urandom, 1'b1);
			xfer({4'h7, s} ^ 7'h08, 5'h0a, 12'h000, 4'hf, 32'h0000_0000, 1'b0);
		end
		frame2(8'h70, 10, 9);
		frame2(8'h70, 7, 7);
		frame2(8'h71, 1, 0);
		chk("second end", {1'b1, 5'h00, 12'h0f8, 4'hf, 32'h1234_5678, 1'b0},
			{n2 == 1, p2, a2, e2, w2, 1'b0});
		chk("queue", 55'h0, 55'(exp_q.size()));
		final_report();
	end
	initial begin
		#5_000_000;
		bad_count++;
		final_report();
	end
endmodule // icw_tb
